// file: design/pps_pin_glue.sv
`timescale 1ns/100ps

// What this block does
// - aux irq 0,1 fire on falling edge only
// - aux irq 2 fires on either edge
// - reset makes all port lines inputs
// - each line's direction and value software set
// - port a shared with aux irqs and keyboard inputs
// - spi owns port c bits 0-3 when enabled
// - port c bits 4,5 serve analog channels
// - port c bits 6,7 feed capture inputs
// - eight-backplane mode reuses backplanes 8-15 as frontplanes
// - registers decoded within 0x00 to 0x2f
// - writes to unimplemented bits ignored
module pps_pin_glue (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rstn,
  input  wire pps_pkg::pps_cpu_req_type            i_cpu_req,
  output logic      [pps_pkg::DATA_W-1:0]          o_cpu_rdata,
  input  wire logic [7:0]                          i_port_a_pin,
  output logic      [7:0]                          o_port_a_out,
  output logic      [7:0]                          o_port_a_oe,
  input  wire logic [7:0]                          i_port_b_pin,
  output logic      [7:0]                          o_port_b_out,
  output logic      [7:0]                          o_port_b_oe,
  input  wire logic [7:0]                          i_port_c_pin,
  output logic      [7:0]                          o_port_c_out,
  output logic      [7:0]                          o_port_c_oe,
  input  wire logic                                i_spi_en,
  input  wire pps_pkg::pps_pin_drv_type [pps_pkg::SPI_N-1:0] i_spi_drv,
  output logic      [pps_pkg::SPI_N-1:0]           o_spi_in,
  input  wire logic [pps_pkg::ADC_N-1:0]           i_adc_en,
  input  wire logic [pps_pkg::CAP_N-1:0]           i_cap_en,
  output logic      [pps_pkg::CAP_N-1:0]           o_capture_in,
  output logic      [pps_pkg::KBD_N-1:0]           o_kbd_in,
  input  wire logic [pps_pkg::AUX_IRQ_N-1:0]       i_irq_clr,
  output logic      [pps_pkg::AUX_IRQ_N-1:0]       o_irq_pend,
  input  wire logic                                i_lcd_mux8,
  input  wire logic [pps_pkg::LCD_BP_N-1:0]        i_lcd_bp,
  input  wire logic [pps_pkg::LCD_EX_N-1:0]        i_lcd_fp_extra,
  output logic      [pps_pkg::LCD_BP_N-1:0]        o_lcd_bp
);

  // ----------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------
  logic [7:0] pa_data_reg;
  logic [7:0] pa_data_next;
  logic [7:0] pb_data_reg;
  logic [7:0] pb_data_next;
  logic [7:0] pc_data_reg;
  logic [7:0] pc_data_next;
  logic [7:0] pa_dir_reg;
  logic [7:0] pa_dir_next;
  logic [7:0] pb_dir_reg;
  logic [7:0] pb_dir_next;
  logic [7:0] pc_dir_reg;
  logic [7:0] pc_dir_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       in_range;

  assign in_range = (i_cpu_req.addr >= pps_pkg::REG_FIRST)
                 && (i_cpu_req.addr <= pps_pkg::REG_LAST);

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------

  always_comb begin
    pa_data_next = pa_data_reg;
    pb_data_next = pb_data_reg;
    pc_data_next = pc_data_reg;
    pa_dir_next  = pa_dir_reg;
    pb_dir_next  = pb_dir_reg;
    pc_dir_next  = pc_dir_reg;
    if (i_cpu_req.wr && in_range) begin
      case (i_cpu_req.addr)
        pps_pkg::ADDR_PTA: pa_data_next = i_cpu_req.wdata;
        pps_pkg::ADDR_PTB: pb_data_next = i_cpu_req.wdata;
        pps_pkg::ADDR_PTC: pc_data_next = i_cpu_req.wdata;
        pps_pkg::ADDR_DDA: pa_dir_next  = i_cpu_req.wdata;
        pps_pkg::ADDR_DDB: pb_dir_next  = i_cpu_req.wdata;
        pps_pkg::ADDR_DDC: pc_dir_next  = i_cpu_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (i_cpu_req.rd && in_range) begin
      case (i_cpu_req.addr)
        pps_pkg::ADDR_PTA: rdata_next = (pa_dir_reg & pa_data_reg) | (~pa_dir_reg & i_port_a_pin);
        pps_pkg::ADDR_PTB: rdata_next = (pb_dir_reg & pb_data_reg) | (~pb_dir_reg & i_port_b_pin);
        pps_pkg::ADDR_PTC: rdata_next = (pc_dir_reg & pc_data_reg) | (~pc_dir_reg & i_port_c_pin);
        pps_pkg::ADDR_DDA: rdata_next = pa_dir_reg;
        pps_pkg::ADDR_DDB: rdata_next = pb_dir_reg;
        pps_pkg::ADDR_DDC: rdata_next = pc_dir_reg;
        default:           rdata_next = pps_pkg::RD_UNUSED;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pa_data_reg <= pps_pkg::RST_DATA;
      pb_data_reg <= pps_pkg::RST_DATA;
      pc_data_reg <= pps_pkg::RST_DATA;
      pa_dir_reg  <= pps_pkg::RST_DIR;
      pb_dir_reg  <= pps_pkg::RST_DIR;
      pc_dir_reg  <= pps_pkg::RST_DIR;
      rdata_reg   <= pps_pkg::RD_UNUSED;
    end else begin
      pa_data_reg <= pa_data_next;
      pb_data_reg <= pb_data_next;
      pc_data_reg <= pc_data_next;
      pa_dir_reg  <= pa_dir_next;
      pb_dir_reg  <= pb_dir_next;
      pc_dir_reg  <= pc_dir_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign o_cpu_rdata  = rdata_reg;

  // ----------------------------------------------------------------
  // port a and b drive
  // ----------------------------------------------------------------
  // plain port drive
  assign o_port_a_out = pa_data_reg;
  assign o_port_a_oe  = pa_dir_reg;
  assign o_port_b_out = pb_data_reg;
  assign o_port_b_oe  = pb_dir_reg;

  // ----------------------------------------------------------------
  // port c sharing
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pc
      if (gi < pps_pkg::SPI_N) begin : g_spi
        assign o_port_c_out[gi] = i_spi_en ? i_spi_drv[gi].o  : pc_data_reg[gi];
        assign o_port_c_oe[gi]  = i_spi_en ? i_spi_drv[gi].oe : pc_dir_reg[gi];
        assign o_spi_in[gi]     = i_port_c_pin[gi];
      end else if (gi < pps_pkg::CAP_LSB) begin : g_adc
        assign o_port_c_out[gi] = pc_data_reg[gi];
        assign o_port_c_oe[gi]  = i_adc_en[gi-pps_pkg::ADC_LSB] ? 1'b0 : pc_dir_reg[gi];
      end else begin : g_cap
        assign o_port_c_out[gi] = pc_data_reg[gi];
        assign o_port_c_oe[gi]  = i_cap_en[gi-pps_pkg::CAP_LSB] ? 1'b0 : pc_dir_reg[gi];
        assign o_capture_in[gi-pps_pkg::CAP_LSB] = i_cap_en[gi-pps_pkg::CAP_LSB]
                                                 & i_port_c_pin[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // aux irq edge detect
  // ----------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_reg;
  logic [2:0] sync2_next;
  logic [2:0] prev_reg;
  logic [2:0] prev_next;
  logic [2:0] pend_reg;
  logic [2:0] pend_next;
  logic [2:0] edge_hit;
  logic [4:0] kbd_s1_reg;
  logic [4:0] kbd_s1_next;
  logic [4:0] kbd_s2_reg;
  logic [4:0] kbd_s2_next;

  always_comb begin
    sync1_next  = i_port_a_pin[pps_pkg::AUX_IRQ_N-1:0];
    sync2_next  = sync1_reg;
    prev_next   = sync2_reg;
    kbd_s1_next = i_port_a_pin[pps_pkg::KBD_LSB +: pps_pkg::KBD_N];
    kbd_s2_next = kbd_s1_reg;
    edge_hit[0] = prev_reg[0] & ~sync2_reg[0];
    edge_hit[1] = prev_reg[1] & ~sync2_reg[1];
    edge_hit[2] = prev_reg[2] ^ sync2_reg[2];
    pend_next   = (pend_reg & ~i_irq_clr) | edge_hit;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg  <= 3'h7;
      sync2_reg  <= 3'h7;
      prev_reg   <= 3'h7;
      pend_reg   <= 3'h0;
      kbd_s1_reg <= 5'h1f;
      kbd_s2_reg <= 5'h1f;
    end else begin
      sync1_reg  <= sync1_next;
      sync2_reg  <= sync2_next;
      prev_reg   <= prev_next;
      pend_reg   <= pend_next;
      kbd_s1_reg <= kbd_s1_next;
      kbd_s2_reg <= kbd_s2_next;
    end
  end

  assign o_irq_pend = pend_reg;
  assign o_kbd_in   = kbd_s2_reg;

  // ----------------------------------------------------------------
  // lcd backplane reuse
  // ----------------------------------------------------------------
  logic [15:0] bp_reg;
  logic [15:0] bp_next;

  always_comb begin
    if (i_lcd_mux8) begin
      bp_next = {i_lcd_fp_extra, i_lcd_bp[pps_pkg::LCD_EX_LSB-1:0]};
    end else begin
      bp_next = i_lcd_bp;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bp_reg <= 16'h0000;
    end else begin
      bp_reg <= bp_next;
    end
  end

  assign o_lcd_bp = bp_reg;

endmodule : pps_pin_glue

// file: inc/pps_pkg.sv
package pps_pkg;

  // ----------------------------------------------------------------
  // register port geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 8;
  localparam logic [5:0]  REG_FIRST = 6'h00;
  localparam logic [5:0]  REG_LAST  = 6'h2f;
  localparam logic [5:0]  ADDR_PTA  = 6'h00;
  localparam logic [5:0]  ADDR_PTB  = 6'h01;
  localparam logic [5:0]  ADDR_PTC  = 6'h02;
  localparam logic [5:0]  ADDR_DDA  = 6'h03;
  localparam logic [5:0]  ADDR_DDB  = 6'h04;
  localparam logic [5:0]  ADDR_DDC  = 6'h05;
  localparam logic [7:0]  RST_DATA  = 8'h00;
  localparam logic [7:0]  RST_DIR   = 8'h00;
  localparam logic [7:0]  RD_UNUSED = 8'h00;

  // ----------------------------------------------------------------
  // pin sharing layout
  // ----------------------------------------------------------------
  localparam int unsigned AUX_IRQ_N = 3;
  localparam int unsigned KBD_LSB   = 3;
  localparam int unsigned KBD_N     = 5;
  localparam int unsigned SPI_N     = 4;
  localparam int unsigned ADC_LSB   = 4;
  localparam int unsigned ADC_N     = 2;
  localparam int unsigned CAP_LSB   = 6;
  localparam int unsigned CAP_N     = 2;
  localparam int unsigned LCD_BP_N  = 16;
  localparam int unsigned LCD_EX_N  = 8;
  localparam int unsigned LCD_EX_LSB = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pps_cpu_req_type;

  typedef struct packed {
    logic o;
    logic oe;
  } pps_pin_drv_type;

endpackage : pps_pkg

// file: verif/pps_board.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// board side of one port, pull-up where nobody drives
// ----------------------------------------------------------------
module pps_board (
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pin
);
  assign o_pin = (i_oe & i_out) | (~i_oe & ((i_ext_en & i_ext) | ~i_ext_en));
endmodule : pps_board

// file: verif/pps_pin_glue_asserts.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port and irq checks
// ----------------------------------------------------------------
module pps_pin_glue_asserts (
  input wire logic                           i_core_clk,
  input wire logic                           i_rstn,
  input wire pps_pkg::pps_cpu_req_type       i_cpu_req,
  input wire logic [7:0]                     o_port_a_oe,
  input wire logic [7:0]                     o_port_b_out,
  input wire logic [7:0]                     o_port_b_oe,
  input wire logic [7:0]                     o_port_c_out,
  input wire logic [7:0]                     o_port_c_oe,
  input wire logic [7:0]                     i_port_a_pin,
  input wire logic                           i_spi_en,
  input wire pps_pkg::pps_pin_drv_type [3:0] i_spi_drv,
  input wire logic [1:0]                     i_adc_en,
  input wire logic [1:0]                     i_cap_en,
  input wire logic [2:0]                     i_irq_clr,
  input wire logic [2:0]                     o_irq_pend,
  input wire logic                           i_lcd_mux8,
  input wire logic [15:0]                    i_lcd_bp,
  input wire logic [7:0]                     i_lcd_fp_extra,
  input wire logic [15:0]                    o_lcd_bp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  a_reset_inputs: assert property (disable iff (1'b0)
    !i_rstn |-> (o_port_a_oe | o_port_b_oe | o_port_c_oe) == 8'h00) else $error("oe in reset");
  a_dir_write: assert property (i_cpu_req.wr && i_cpu_req.addr == pps_pkg::ADDR_DDB
    |=> o_port_b_oe == $past(i_cpu_req.wdata)) else $error("dir write lost");
  a_far_ignored: assert property (i_cpu_req.wr && i_cpu_req.addr > pps_pkg::REG_LAST
    |=> $stable(o_port_b_out)) else $error("far write acted");
  a_spi_route: assert property (i_spi_en |-> o_port_c_out[0] == i_spi_drv[0].o
    && o_port_c_oe[3] == i_spi_drv[3].oe) else $error("spi not routed");
  a_alt_release: assert property ((i_adc_en & o_port_c_oe[5:4]) == 2'b00
    && (i_cap_en & o_port_c_oe[7:6]) == 2'b00) else $error("alt pin driven");
  a_lcd_remap: assert property (i_lcd_mux8
    |=> o_lcd_bp[15:8] == $past(i_lcd_fp_extra)) else $error("extra fp missing");
  a_lcd_plain: assert property (!i_lcd_mux8
    |=> o_lcd_bp == $past(i_lcd_bp)) else $error("backplane wrong");
  a_fall_cause: assert property ($rose(o_irq_pend[0])
    |-> $past(i_port_a_pin[0], 4) && !$past(i_port_a_pin[0], 3)) else $error("aux_irq_in_0 no fall");
  a_both_edges: assert property ($rose(o_irq_pend[2])
    |-> $past(i_port_a_pin[2], 4) != $past(i_port_a_pin[2], 3)) else $error("aux_irq_in_2 no edge");
  a_fall_sets: assert property ($fell(i_port_a_pin[1])
    |-> ##3 o_irq_pend[1]) else $error("aux_irq_in_1 fall missed");
  a_pend_sticky: assert property (o_irq_pend[0] && !i_irq_clr[0]
    |=> o_irq_pend[0]) else $error("pend dropped");
endmodule : pps_pin_glue_asserts
bind pps_pin_glue pps_pin_glue_asserts pps_pin_glue_asserts_inst (.i_core_clk(i_core_clk),
  .i_rstn(i_rstn), .i_cpu_req(i_cpu_req), .o_port_a_oe(o_port_a_oe),
  .o_port_b_out(o_port_b_out), .o_port_b_oe(o_port_b_oe), .o_port_c_out(o_port_c_out),
  .o_port_c_oe(o_port_c_oe), .i_port_a_pin(i_port_a_pin), .i_spi_en(i_spi_en),
  .i_spi_drv(i_spi_drv), .i_adc_en(i_adc_en), .i_cap_en(i_cap_en), .i_irq_clr(i_irq_clr),
  .o_irq_pend(o_irq_pend), .i_lcd_mux8(i_lcd_mux8), .i_lcd_bp(i_lcd_bp),
  .i_lcd_fp_extra(i_lcd_fp_extra), .o_lcd_bp(o_lcd_bp));

// file: verif/pps_pin_glue_tb.sv
`timescale 1ns/100ps
`define PPS_CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pps_pin_glue_tb;
  // ----------------------------------------------------------------
  // stimulus, model and checks
  // ----------------------------------------------------------------
  logic i_core_clk = 1'b0, i_rstn = 1'b0, spi_en = 1'b0, mux8 = 1'b0;
  pps_pkg::pps_cpu_req_type       req = '0;
  pps_pkg::pps_pin_drv_type [3:0] spi_drv = '0;
  logic [7:0] pin [3], out [3], oe [3], ext [3], rdata, fpx = 8'h00, ext_en = 8'hff;
  logic [3:0] spi_in;
  logic [1:0] adc_en = 2'b00, cap_en = 2'b00, cap_in;
  logic [4:0] kbd;
  logic [2:0] clr = 3'h0, pend;
  logic [15:0] bp = 16'h0000, lcd;
  int err_total = 0, cmp_count = 0, seed = 32'h445efb83, p, dir_m [3], dat_m [3];
  always #10 i_core_clk = ~i_core_clk;
  pps_pin_glue pps_pin_glue_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cpu_req(req),
    .o_cpu_rdata(rdata), .i_port_a_pin(pin[0]), .o_port_a_out(out[0]), .o_port_a_oe(oe[0]),
    .i_port_b_pin(pin[1]), .o_port_b_out(out[1]), .o_port_b_oe(oe[1]),
    .i_port_c_pin(pin[2]), .o_port_c_out(out[2]), .o_port_c_oe(oe[2]), .i_spi_en(spi_en),
    .i_spi_drv(spi_drv), .o_spi_in(spi_in), .i_adc_en(adc_en), .i_cap_en(cap_en),
    .o_capture_in(cap_in), .o_kbd_in(kbd), .i_irq_clr(clr), .o_irq_pend(pend),
    .i_lcd_mux8(mux8), .i_lcd_bp(bp), .i_lcd_fp_extra(fpx), .o_lcd_bp(lcd));
  for (genvar k = 0; k < 3; k++) begin : g_port
    pps_board pps_board_inst (.i_out(out[k]), .i_oe(oe[k]), .i_ext(ext[k]),
      .i_ext_en(ext_en), .o_pin(pin[k]));
  end
  function automatic logic [7:0] exp_pin(int q);
    return 8'((dir_m[q] & dat_m[q]) | (~dir_m[q] & ((ext_en & ext[q]) | ~ext_en)));
  endfunction : exp_pin
  task automatic acc(logic w, logic [5:0] a, logic [7:0] d);
    @(negedge i_core_clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    if (w && a < 6'h06) begin
      if (a < 6'h03) dat_m[a] = d; else dir_m[a-3] = d;
    end
    @(negedge i_core_clk);
    req = '0;
  endtask : acc
  task automatic conclude;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #1000000;
    err_total++;
    conclude();
  end
  initial begin
    ext = '{8'hff, 8'hff, 8'hff};
    repeat (10) @(negedge i_core_clk);
    i_rstn = 1'b1;
    for (int q = 0; q < 3; q++) `PPS_CHK(oe[q], 8'h00)
    `PPS_CHK(pend, 3'h0)
    ext_en = 8'($random(seed));
    for (int n = 0; n < 9; n++) begin
      p = n % 3;
      if (p != 0) ext[p] = 8'($random(seed));
      acc(1'b1, 6'(p + 3), 8'($random(seed)));
      acc(1'b1, 6'(p), 8'($random(seed)));
      `PPS_CHK(oe[p], 8'(dir_m[p]))
      `PPS_CHK(out[p], 8'(dat_m[p]))
      acc(1'b0, 6'(p), 8'h00);
      `PPS_CHK(rdata, exp_pin(p))
    end
    acc(1'b1, 6'h30 | 6'($random(seed)), 8'h5a);
    for (int q = 0; q < 3; q++) `PPS_CHK({out[q], oe[q]}, {8'(dat_m[q]), 8'(dir_m[q])})
    acc(1'b1, 6'h06, 8'ha5);
    acc(1'b0, 6'h06, 8'h00);
    `PPS_CHK(rdata, 8'h00)
    acc(1'b0, 6'h01, 8'h00);
    acc(1'b0, 6'h3f, 8'h00);
    `PPS_CHK(rdata, exp_pin(1))
    acc(1'b1, 6'h05, 8'hff);
    spi_en = 1'b1;
    spi_drv = 8'($random(seed));
    {adc_en, cap_en} = 4'hf;
    #1;
    for (int k = 0; k < 4; k++) `PPS_CHK({out[2][k], oe[2][k]}, spi_drv[k])
    `PPS_CHK(spi_in, pin[2][3:0])
    `PPS_CHK(oe[2][7:4], 4'h0)
    `PPS_CHK(cap_in, pin[2][7:6])
    {spi_en, adc_en, cap_en} = 5'h00;
    #1;
    `PPS_CHK({out[2], oe[2], cap_in}, {8'(dat_m[2]), 8'hff, 2'b00})
    repeat (8) begin
      @(negedge i_core_clk);
      {mux8, bp, fpx} = 25'($random(seed));
      @(negedge i_core_clk);
      `PPS_CHK(lcd, mux8 ? {fpx, bp[7:0]} : bp)
    end
    acc(1'b1, 6'h03, 8'h00);
    ext_en = 8'hff;
    ext[0] = 8'hff;
    clr = 3'h7;
    repeat (4) @(negedge i_core_clk);
    clr = 3'h0;
    `PPS_CHK(pend, 3'h0)
    for (int k = 0; k < 3; k++) begin
      ext[0] = {5'($random(seed)), 3'h7};
      ext[0][k] = 1'b0;
      repeat (4) @(negedge i_core_clk);
      `PPS_CHK(pend[k], 1'b1)
      `PPS_CHK(kbd, ext[0][7:3])
      clr[k] = 1'b1;
      @(negedge i_core_clk);
      clr = 3'h0;
      repeat (2) @(negedge i_core_clk);
      ext[0][k] = 1'b1;
      repeat (4) @(negedge i_core_clk);
      `PPS_CHK(pend[k], 1'(k == 2))
    end
    conclude();
  end
endmodule : pps_pin_glue_tb
